// *** logic/core_sfr_pkg.sv ***
// Constants and types for the core status, option and interrupt control registers.
// Assumes the datapath presents 9-bit data-memory addresses and 8-bit data.
package core_sfr_pkg;

    // Register decode: status mirrored in every bank, option in banks 1 and 3,
    // interrupt control in banks 2 and 3
    localparam logic [6:0] STATUS_LOW_OFFSET = 7'h03;
    localparam logic [7:0] OPTION_LOW_OFFSET = 8'h81;
    localparam logic [6:0] INTERRUPT_CONTROL_LOW_OFFSET = 7'h0b;
    localparam logic [8:0] STATUS_ADDR       = 9'h003;
    localparam logic [8:0] OPTION_ADDR       = 9'h081;
    localparam logic [8:0] INTERRUPT_CONTROL_ADDR       = 9'h10b;

    // Status fields
    localparam int ST_INDIRECT_BANK = 7;
    localparam int ST_DIRECT_HI     = 6;
    localparam int ST_DIRECT_LO     = 5;
    localparam int ST_TIMEOUT       = 4;
    localparam int ST_POWERDOWN     = 3;
    localparam int ST_NULL          = 2;
    localparam int ST_NIBBLE_CARRY  = 1;
    localparam int ST_WORD_CARRY    = 0;
    localparam logic [7:0] STATUS_RESET    = 8'h18;
    localparam logic [7:0] STATUS_SW_MASK  = 8'he7;

    // Option fields
    localparam int OPT_PULLUP_OFF_N = 7;
    localparam int OPT_EXT_RISING   = 6;
    localparam int OPT_T0_EXT_CLK   = 5;
    localparam int OPT_T0_FALL_EDGE = 4;
    localparam int OPT_PRESCALE_WDT = 3;
    localparam int OPT_RATE_HI      = 2;
    localparam logic [7:0] OPTION_RESET = 8'hff;

    // Interrupt control fields
    localparam int IC_GLOBAL_EN     = 7;
    localparam int IC_PERIPH_EN     = 6;
    localparam int IC_TIMER_EN      = 5;
    localparam int IC_EXT_EN        = 4;
    localparam int IC_PORT_EN       = 3;
    localparam int IC_TIMER_FLAG    = 2;
    localparam int IC_EXT_FLAG      = 1;
    localparam int IC_PORT_FLAG     = 0;
    localparam logic [7:0] INTERRUPT_CONTROL_RESET = 8'h00;

    // Synchronised pin vector layout
    localparam int PIN_COUNT   = 6;
    localparam int PIN_EXT     = 0;
    localparam int PIN_T0_CLK  = 1;
    localparam int PIN_PORT_LO = 2;
    localparam logic [2:0] SYNC_RESET = 3'h0;

    typedef enum logic [3:0] {
        FLAG_NONE = 4'h1,
        FLAG_ADD  = 4'h2,
        FLAG_SUB  = 4'h4,
        FLAG_NULL = 4'h8
    } flag_op_t;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] option;
        logic [7:0] interrupt_control;
        logic [7:0] rd_data;
        logic       irq;
        logic [7:0] timer;
        logic [7:0] prescale;
        logic       wdt_tick;
    } sfr_state_t;

    typedef struct packed {
        logic [PIN_COUNT-1:0] s1;
        logic [PIN_COUNT-1:0] s2;
        logic [PIN_COUNT-1:0] s3;
        logic [PIN_COUNT-1:0] level;
        logic [PIN_COUNT-1:0] rise;
        logic [PIN_COUNT-1:0] fall;
    } pin_sync_t;

endpackage

// *** logic/core_status_irq_regs.sv ***
// Core status, option and interrupt control registers with timer_zero,
// shared prescaler and interrupt request generation.
// Assumes the instruction datapath drives one access per cycle on clk_sys,
// and that reset-cause events arrive as one-cycle pulses.
//
// Functional notes
// - Status register accepts writes from any instruction, subject to masking.
// - If the instruction sets arithmetic flags, their written bits are discarded.
// - Timeout and powerdown bits ignore software writes entirely.
// - Clearing status zeroes bank bits and carry flags, sets null flag, keeps timeout and powerdown.
// - Bit set/clear, swap and move leave the arithmetic flags alone.
// - In subtraction both carry flags mean no borrow when set.
// - Status register appears at the same offset in all four banks.
// - Status bank bits select direct bank and indirect bank half.
// - Option register is read/write at two mirrored addresses.
// - Timer_zero counts 1:1 when the prescaler serves the watchdog.
// - Interrupt control register is read/write with enables and flags.
// - Interrupt control register is mirrored at two upper-bank addresses.
// - Flags set on their condition regardless of any enable.
`timescale 1ns/1ps
module core_status_irq_regs import core_sfr_pkg::*; (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    // Register access from the datapath
    input  wire logic [8:0] sfr_addr,
    input  wire logic       sfr_wr_en,
    input  wire logic [7:0] sfr_wr_data,
    input  wire logic       sfr_rd_en,
    output logic [7:0]      sfr_rd_data,
    // Arithmetic flag source
    input  wire flag_op_t   flag_op,
    input  wire logic [7:0] flag_opnd_a,
    input  wire logic [7:0] flag_opnd_b,
    // Reset-cause events
    input  wire logic       wdt_clear_exec,
    input  wire logic       sleep_exec,
    input  wire logic       wdt_timeout,
    // Timing sources
    input  wire logic       instr_tick,
    input  wire logic       wdt_osc_tick,
    // Pins
    input  wire logic       ext_interrupt_pin,
    input  wire logic       timer_zero_clk_pin,
    input  wire logic [3:0] port_b_upper,
    // Interrupts
    input  wire logic       periph_irq_pending,
    output logic            irq_req,
    // Status and control outputs
    output logic [1:0]      direct_bank_sel,
    output logic            indirect_bank_select,
    output logic            pullups_off_n,
    output logic [7:0]      timer_zero,
    output logic            wdt_prescaled_tick
);
    sfr_state_t q, d;

    logic       null_val;
    logic       nibble_val;
    logic       word_val;
    logic       upd_null;
    logic       upd_carries;

    pin_event_if ev ();

    status_flag_calc u_flags (
        .op          (flag_op),
        .opnd_a      (flag_opnd_a),
        .opnd_b      (flag_opnd_b),
        .null_val    (null_val),
        .nibble_val  (nibble_val),
        .word_val    (word_val),
        .upd_null    (upd_null),
        .upd_carries (upd_carries)
    );

    pin_event_sync u_pins (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .pins_raw ({port_b_upper, timer_zero_clk_pin, ext_interrupt_pin}),
        .ev       (ev.src)
    );

    function automatic logic hit_status(input logic [8:0] a);
        return a[6:0] == STATUS_LOW_OFFSET;
    endfunction

    function automatic logic hit_option(input logic [8:0] a);
        return a[7:0] == OPTION_LOW_OFFSET;
    endfunction

    function automatic logic hit_interrupt_control(input logic [8:0] a);
        return a[8] && (a[6:0] == INTERRUPT_CONTROL_LOW_OFFSET);
    endfunction

    // Prescaler fires every 2^(rate+1) input ticks
    function automatic logic prescale_done(input logic [7:0] cnt, input logic [2:0] rate);
        logic [7:0] mask;
        mask = 8'((9'h002 << rate) - 9'h001);
        return (cnt & mask) == mask;
    endfunction

    logic       wr_status;
    logic       wr_option;
    logic       wr_interrupt_control;
    logic       t0_edge;
    logic       t0_src_tick;
    logic       pre_in;
    logic       pre_fire;
    logic       t0_inc;
    logic       ext_event;
    logic       port_event;
    logic       timer_event;
    logic [7:0] sw_st;

    always_comb begin
        d = q;

        wr_status = sfr_wr_en && hit_status(sfr_addr);
        wr_option = sfr_wr_en && hit_option(sfr_addr);
        wr_interrupt_control = sfr_wr_en && hit_interrupt_control(sfr_addr);

        // Status: software writes reach bank bits and, unless the
        // instruction owns them, the arithmetic flags
        sw_st = wr_status ? sfr_wr_data : q.status;
        d.status[ST_INDIRECT_BANK] = sw_st[ST_INDIRECT_BANK];
        d.status[ST_DIRECT_HI]     = sw_st[ST_DIRECT_HI];
        d.status[ST_DIRECT_LO]     = sw_st[ST_DIRECT_LO];
        // Bit ops, swap and move arrive as FLAG_NONE and so keep the written
        // value; a clear arrives as FLAG_NULL with zero data
        d.status[ST_NULL]         = upd_null    ? null_val   : sw_st[ST_NULL];
        d.status[ST_NIBBLE_CARRY] = upd_carries ? nibble_val : sw_st[ST_NIBBLE_CARRY];
        d.status[ST_WORD_CARRY]   = upd_carries ? word_val   : sw_st[ST_WORD_CARRY];

        // Reset-cause bits never take software data; a timeout beats the
        // instruction events so a pending timeout is never hidden
        if (wdt_clear_exec) begin
            d.status[ST_TIMEOUT]   = 1'b1;
            d.status[ST_POWERDOWN] = 1'b1;
        end else if (sleep_exec) begin
            d.status[ST_TIMEOUT]   = 1'b1;
            d.status[ST_POWERDOWN] = 1'b0;
        end
        if (wdt_timeout) begin
            d.status[ST_TIMEOUT] = 1'b0;
        end

        if (wr_option) begin
            d.option = sfr_wr_data;
        end

        // Timer_zero clock source and shared prescaler
        t0_edge     = q.option[OPT_T0_FALL_EDGE] ? ev.fall[PIN_T0_CLK] : ev.rise[PIN_T0_CLK];
        t0_src_tick = q.option[OPT_T0_EXT_CLK] ? t0_edge : instr_tick;
        pre_in      = q.option[OPT_PRESCALE_WDT] ? wdt_osc_tick : t0_src_tick;
        pre_fire    = pre_in && prescale_done(q.prescale, q.option[OPT_RATE_HI -: 3]);
        if (pre_in) begin
            d.prescale = pre_fire ? 8'h00 : q.prescale + 8'h01;
        end
        // Switching the assignment must not carry a partial count across
        if (wr_option && (sfr_wr_data[OPT_PRESCALE_WDT] != q.option[OPT_PRESCALE_WDT])) begin
            d.prescale = 8'h00;
        end
        t0_inc     = q.option[OPT_PRESCALE_WDT] ? t0_src_tick : pre_fire;
        d.wdt_tick = q.option[OPT_PRESCALE_WDT] && pre_fire;
        if (t0_inc) begin
            d.timer = q.timer + 8'h01;
        end

        // Interrupt events
        timer_event = t0_inc && (q.timer == 8'hff);
        ext_event   = q.option[OPT_EXT_RISING] ? ev.rise[PIN_EXT] : ev.fall[PIN_EXT];
        port_event  = |(ev.rise[PIN_COUNT-1:PIN_PORT_LO] | ev.fall[PIN_COUNT-1:PIN_PORT_LO]);

        if (wr_interrupt_control) begin
            d.interrupt_control = sfr_wr_data;
        end
        // Hardware set wins over a same-cycle software clear
        if (timer_event) begin
            d.interrupt_control[IC_TIMER_FLAG] = 1'b1;
        end
        if (ext_event) begin
            d.interrupt_control[IC_EXT_FLAG] = 1'b1;
        end
        if (port_event) begin
            d.interrupt_control[IC_PORT_FLAG] = 1'b1;
        end

        d.irq = q.interrupt_control[IC_GLOBAL_EN] && (
                (q.interrupt_control[IC_TIMER_EN] && q.interrupt_control[IC_TIMER_FLAG]) ||
                (q.interrupt_control[IC_EXT_EN]   && q.interrupt_control[IC_EXT_FLAG])   ||
                (q.interrupt_control[IC_PORT_EN]  && q.interrupt_control[IC_PORT_FLAG])  ||
                (q.interrupt_control[IC_PERIPH_EN] && periph_irq_pending));

        // Reads return the value held before any same-cycle write
        if (sfr_rd_en) begin
            if (hit_status(sfr_addr)) begin
                d.rd_data = q.status;
            end else if (hit_option(sfr_addr)) begin
                d.rd_data = q.option;
            end else if (hit_interrupt_control(sfr_addr)) begin
                d.rd_data = q.interrupt_control;
            end else begin
                d.rd_data = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            q.status   <= STATUS_RESET;
            q.option   <= OPTION_RESET;
            q.interrupt_control   <= INTERRUPT_CONTROL_RESET;
            q.rd_data  <= 8'h00;
            q.irq      <= 1'b0;
            q.timer    <= 8'h00;
            q.prescale <= 8'h00;
            q.wdt_tick <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign sfr_rd_data          = q.rd_data;
    assign irq_req              = q.irq;
    assign direct_bank_sel      = q.status[ST_DIRECT_HI:ST_DIRECT_LO];
    assign indirect_bank_select = q.status[ST_INDIRECT_BANK];
    assign pullups_off_n        = q.option[OPT_PULLUP_OFF_N];
    assign timer_zero           = q.timer;
    assign wdt_prescaled_tick   = q.wdt_tick;
endmodule

// *** logic/pin_event_if.sv ***
// Carrier for filtered pin levels and edge pulses from the pin synchroniser.
// Assumes a single clk_sys domain on both ends.
`timescale 1ns/1ps
interface pin_event_if;
    import core_sfr_pkg::*;
    logic [PIN_COUNT-1:0] level;
    logic [PIN_COUNT-1:0] rise;
    logic [PIN_COUNT-1:0] fall;
    modport src (output level, output rise, output fall);
    modport snk (input level, input rise, input fall);
endinterface

// *** logic/pin_event_sync.sv ***
// Three-stage synchroniser and edge detector for asynchronous pins.
// Assumes raw pins may change at any time relative to clk_sys.
`timescale 1ns/1ps
module pin_event_sync import core_sfr_pkg::*; (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst_b,
    // Raw pins
    input  wire logic [PIN_COUNT-1:0] pins_raw,
    // Filtered events
    pin_event_if.src                  ev
);
    pin_sync_t q, d;

    // A level counts only once the second and third stages agree
    always_comb begin
        d       = q;
        d.s1    = pins_raw;
        d.s2    = q.s1;
        d.s3    = q.s2;
        d.level = (q.s2 & q.s3) | (q.level & (q.s2 | q.s3));
        d.rise  = d.level & ~q.level;
        d.fall  = ~d.level & q.level;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign ev.level = q.level;
    assign ev.rise  = q.rise;
    assign ev.fall  = q.fall;
endmodule

// *** logic/status_flag_calc.sv ***
// Arithmetic flag generator for the status register.
// Assumes the datapath gives both operands; combinational, no state.
`timescale 1ns/1ps
module status_flag_calc import core_sfr_pkg::*; (
    // Operation and operands
    input  wire flag_op_t   op,
    input  wire logic [7:0] opnd_a,
    input  wire logic [7:0] opnd_b,
    // Flag results and which of them the operation owns
    output logic            null_val,
    output logic            nibble_val,
    output logic            word_val,
    output logic            upd_null,
    output logic            upd_carries
);
    logic       sub;
    logic [7:0] b_eff;
    logic [4:0] low_sum;
    logic [8:0] full_sum;

    // Subtraction adds the complement plus one, so a carry out means no borrow
    always_comb begin
        sub         = (op == FLAG_SUB);
        b_eff       = sub ? ~opnd_b : opnd_b;
        low_sum     = {1'b0, opnd_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, sub};
        full_sum    = {1'b0, opnd_a} + {1'b0, b_eff} + {8'h00, sub};
        nibble_val  = low_sum[4];
        word_val    = full_sum[8];
        null_val    = (op == FLAG_NULL) ? (opnd_a == 8'h00) : (full_sum[7:0] == 8'h00);
        upd_null    = (op != FLAG_NONE);
        upd_carries = (op == FLAG_ADD) || (op == FLAG_SUB);
    end
endmodule

// *** tb/core_datapath_model.sv ***
// Instruction datapath stand-in: issues one register access at a time.
// Assumes clk_sys is free running; signals change 1 ns after a rising edge.
`timescale 1ns/1ps
module core_datapath_model import core_sfr_pkg::*; (
    // Clock
    input  wire logic       clk_sys,
    // Register access
    output logic [8:0]      sfr_addr,
    output logic            sfr_wr_en,
    output logic [7:0]      sfr_wr_data,
    output logic            sfr_rd_en,
    input  wire logic [7:0] sfr_rd_data,
    // Flag source
    output flag_op_t        flag_op,
    output logic [7:0]      flag_opnd_a,
    output logic [7:0]      flag_opnd_b
);
    initial begin
        sfr_addr = 9'h000;
        sfr_wr_en = 1'b0;
        sfr_wr_data = 8'h00;
        sfr_rd_en = 1'b0;
        flag_op = FLAG_NONE;
        flag_opnd_a = 8'h00;
        flag_opnd_b = 8'h00;
    end

    // Idle bus shows inverted values so a stale address is never mistaken for a hold
    task automatic access(input logic we, input logic [8:0] a, input logic [7:0] d, input flag_op_t op,
                          input logic [7:0] x, input logic [7:0] y, output logic [7:0] q);
        @(posedge clk_sys);
        #1;
        sfr_wr_en = we;
        sfr_rd_en = !we;
        sfr_addr = a;
        sfr_wr_data = d;
        flag_op = op;
        flag_opnd_a = x;
        flag_opnd_b = y;
        @(posedge clk_sys);
        #1;
        q = sfr_rd_data;
        sfr_wr_en = 1'b0;
        sfr_rd_en = 1'b0;
        sfr_addr = ~a;
        sfr_wr_data = ~d;
        flag_op = FLAG_NONE;
    endtask
endmodule

// *** tb/core_status_irq_asserts.sv ***
// Port-level checks for the core status, option and interrupt control registers.
// Assumes it is bound to core_status_irq_regs and sees only that module's ports.
`timescale 1ns/1ps
module core_status_irq_asserts (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       rst_b,
    // Register access
    input wire logic [8:0] sfr_addr,
    input wire logic       sfr_wr_en,
    input wire logic [7:0] sfr_wr_data,
    input wire logic       sfr_rd_en,
    input wire logic [7:0] sfr_rd_data,
    // Peripheral request input, interrupt and status outputs
    input wire logic       periph_irq_pending,
    input wire logic       irq_req,
    input wire logic [1:0] direct_bank_sel,
    input wire logic       indirect_bank_select,
    input wire logic       pullups_off_n,
    input wire logic [7:0] timer_zero
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    logic       st_wr;
    logic       ic_wr;
    logic       wr_pu;
    logic [2:0] wr_hi;
    logic [2:0] bank;
    assign st_wr = sfr_wr_en && sfr_addr[6:0] == 7'h03;
    assign ic_wr = sfr_wr_en && sfr_addr[8] && sfr_addr[6:0] == 7'h0b;
    assign wr_pu = sfr_wr_data[7];
    assign wr_hi = sfr_wr_data[7:5];
    assign bank  = {indirect_bank_select, direct_bank_sel};

    chk_read_hold: assert property (!sfr_rd_en |=> $stable(sfr_rd_data))
        else $error("read data moved without a read");
    chk_unmapped_read: assert property (sfr_rd_en && sfr_addr == 9'h08b |=> sfr_rd_data == 8'h00)
        else $error("unmapped read not zero");
    chk_bank_write: assert property (st_wr |=> bank == $past(wr_hi))
        else $error("bank bits missed a status write");
    chk_bank_hold: assert property (!st_wr |=> $stable(bank))
        else $error("bank bits moved without a status write");
    chk_bank_read: assert property (sfr_rd_en && sfr_addr[6:0] == 7'h03 |=> sfr_rd_data[7:5] == $past(bank))
        else $error("status read disagrees with bank outputs");
    chk_option_write: assert property (sfr_wr_en && sfr_addr[7:0] == 8'h81 |=> pullups_off_n == $past(wr_pu))
        else $error("pull-up control missed an option write");
    chk_irq_off: assert property (ic_wr && !sfr_wr_data[7] ##1 !ic_wr |=> !irq_req)
        else $error("request without global enable");
    chk_irq_sticky: assert property (!periph_irq_pending && !ic_wr ##1 irq_req && !periph_irq_pending |=> irq_req)
        else $error("request dropped without a software clear");
    chk_timer_step: assert property ($past(rst_b) && !$stable(timer_zero) |-> timer_zero == $past(timer_zero) + 8'h01)
        else $error("timer moved by other than one");
endmodule

// *** tb/test_core_status_and_interrupt_control.sv ***
// Self-checking bench: register rows, reset-cause events, timer_zero and interrupts.
// Assumes core_datapath_model issues every register access.
`timescale 1ns/1ps
module test_core_status_and_interrupt_control import core_sfr_pkg::*; ;
    typedef struct packed {
        logic [8:0] wa; logic [7:0] wd; flag_op_t op; logic [7:0] x; logic [7:0] y; logic [8:0] ra; logic [7:0] ex;
    } row_t;
    row_t rows [11] = '{
        '{9'h003, 8'hff, FLAG_NONE, 8'h00, 8'h00, 9'h003, 8'hff},
        '{9'h183, 8'ha0, FLAG_NONE, 8'h00, 8'h00, 9'h083, 8'hb8},
        '{9'h103, 8'h07, FLAG_NULL, 8'h05, 8'h00, 9'h003, 8'h1b},
        '{9'h003, 8'h00, FLAG_SUB, 8'h10, 8'h01, 9'h103, 8'h19},
        '{9'h083, 8'h00, FLAG_SUB, 8'h05, 8'h05, 9'h183, 8'h1f},
        '{9'h003, 8'he5, FLAG_ADD, 8'h08, 8'h08, 9'h003, 8'hfa},
        '{9'h003, 8'h00, FLAG_ADD, 8'hff, 8'h01, 9'h003, 8'h1f},
        '{9'h081, 8'h5a, FLAG_NONE, 8'h00, 8'h00, 9'h181, 8'h5a},
        '{9'h18b, 8'h7f, FLAG_NONE, 8'h00, 8'h00, 9'h10b, 8'h7f},
        '{9'h10b, 8'h00, FLAG_NONE, 8'h00, 8'h00, 9'h18b, 8'h00},
        '{9'h08b, 8'h55, FLAG_NONE, 8'h00, 8'h00, 9'h08b, 8'h00}};
    logic clk_sys = 1'b0, rst_b = 1'b0, sfr_wr_en, sfr_rd_en, irq_req, indirect_bank_select, pullups_off_n;
    logic wdt_clear_exec = 1'b0, sleep_exec = 1'b0, wdt_timeout = 1'b0, instr_tick = 1'b0, ext_pin = 1'b0;
    logic pend = 1'b0, wdt_osc = 1'b0, wdt_prescaled_tick;
    logic [8:0] sfr_addr;
    logic [7:0] sfr_wr_data, sfr_rd_data, flag_opnd_a, flag_opnd_b, timer_zero, q;
    logic [3:0] port_b = 4'h0;
    logic [1:0] direct_bank_sel;
    flag_op_t   flag_op;
    int         n_fail = 0;
    int         tests_run = 0;

    always #2.5 clk_sys = ~clk_sys;

    core_datapath_model dp (.clk_sys(clk_sys), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
        .sfr_wr_data(sfr_wr_data), .sfr_rd_en(sfr_rd_en), .sfr_rd_data(sfr_rd_data), .flag_op(flag_op),
        .flag_opnd_a(flag_opnd_a), .flag_opnd_b(flag_opnd_b));
    core_status_irq_regs dut (.clk_sys(clk_sys), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
        .sfr_wr_data(sfr_wr_data), .sfr_rd_en(sfr_rd_en), .sfr_rd_data(sfr_rd_data), .flag_op(flag_op),
        .flag_opnd_a(flag_opnd_a), .flag_opnd_b(flag_opnd_b), .wdt_clear_exec(wdt_clear_exec),
        .sleep_exec(sleep_exec), .wdt_timeout(wdt_timeout), .instr_tick(instr_tick), .wdt_osc_tick(wdt_osc),
        .ext_interrupt_pin(ext_pin), .timer_zero_clk_pin(1'b0), .port_b_upper(port_b),
        .periph_irq_pending(pend), .irq_req(irq_req), .direct_bank_sel(direct_bank_sel),
        .indirect_bank_select(indirect_bank_select), .pullups_off_n(pullups_off_n), .timer_zero(timer_zero),
        .wdt_prescaled_tick(wdt_prescaled_tick));

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        dp.access(1'b1, a, d, FLAG_NONE, 8'h00, 8'h00, q);
    endtask
    task automatic rdchk(input logic [8:0] a, input logic [7:0] exp);
        dp.access(1'b0, a, 8'h00, FLAG_NONE, 8'h00, 8'h00, q);
        check(q, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic pulse(ref logic s);
        cyc(1);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask
    task automatic results();
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #50000;
        n_fail++;
        results();
    end

    initial begin
        cyc(10);
        rst_b = 1'b1;
        foreach (rows[i]) begin
            dp.access(1'b1, rows[i].wa, rows[i].wd, rows[i].op, rows[i].x, rows[i].y, q);
            rdchk(rows[i].ra, rows[i].ex);
        end
        $display("register rows done");
        dp.access(1'b1, 9'h003, 8'he0, FLAG_NULL, 8'h01, 8'h00, q);
        rdchk(9'h003, 8'hf8);
        pulse(sleep_exec);
        rdchk(9'h003, 8'hf0);
        pulse(wdt_timeout);
        rdchk(9'h003, 8'he0);
        pulse(wdt_clear_exec);
        rdchk(9'h003, 8'hf8);
        pulse(wdt_timeout);
        wr(9'h003, 8'h10);
        rdchk(9'h003, 8'h08);
        dp.access(1'b1, 9'h003, 8'h00, FLAG_NULL, 8'h00, 8'h00, q);
        rdchk(9'h083, 8'h0c);
        $display("reset-cause tests done");
        wr(9'h081, 8'h48);
        check({7'h00, pullups_off_n}, 8'h00);
        instr_tick = 1'b1;
        cyc(5);
        instr_tick = 1'b0;
        cyc(3);
        check(timer_zero, 8'h05);
        instr_tick = 1'b1;
        cyc(251);
        instr_tick = 1'b0;
        cyc(3);
        check(timer_zero, 8'h00);
        // Prescaler on the timer at its smallest rate halves the count
        wr(9'h081, 8'h40);
        instr_tick = 1'b1;
        cyc(4);
        instr_tick = 1'b0;
        cyc(3);
        check(timer_zero, 8'h02);
        wr(9'h081, 8'h48);
        pulse(wdt_osc);
        check({7'h00, wdt_prescaled_tick}, 8'h00);
        pulse(wdt_osc);
        check({7'h00, wdt_prescaled_tick}, 8'h01);
        rdchk(9'h10b, 8'h04);
        wr(9'h10b, 8'ha4);
        cyc(2);
        check({7'h00, irq_req}, 8'h01);
        wr(9'h10b, 8'ha0);
        cyc(2);
        check({7'h00, irq_req}, 8'h00);
        $display("timer tests done");
        wr(9'h10b, 8'h00);
        ext_pin = 1'b1;
        cyc(8);
        rdchk(9'h10b, 8'h02);
        cyc(20);
        rdchk(9'h18b, 8'h02);
        check({7'h00, irq_req}, 8'h00);
        wr(9'h10b, 8'h00);
        wr(9'h10b, 8'h88);
        port_b = 4'h4;
        cyc(8);
        check({7'h00, irq_req}, 8'h01);
        rdchk(9'h18b, 8'h89);
        wr(9'h10b, 8'hc0);
        pend = 1'b1;
        cyc(2);
        check({7'h00, irq_req}, 8'h01);
        wr(9'h10b, 8'h40);
        cyc(2);
        check({7'h00, irq_req}, 8'h00);
        $display("interrupt tests done");
        pend = 1'b0;
        ext_pin = 1'b0;
        port_b = 4'h0;
        cyc(10);
        rst_b = 1'b0;
        cyc(10);
        rst_b = 1'b1;
        rdchk(9'h003, 8'h18);
        rdchk(9'h081, 8'hff);
        rdchk(9'h10b, 8'h00);
        check(timer_zero, 8'h00);
        $display("reset tests done");
        results();
    end
endmodule

bind core_status_irq_regs core_status_irq_asserts chk (.clk_sys(clk_sys), .rst_b(rst_b), .sfr_addr(sfr_addr),
    .sfr_wr_en(sfr_wr_en), .sfr_wr_data(sfr_wr_data), .sfr_rd_en(sfr_rd_en), .sfr_rd_data(sfr_rd_data),
    .periph_irq_pending(periph_irq_pending), .irq_req(irq_req), .direct_bank_sel(direct_bank_sel),
    .indirect_bank_select(indirect_bank_select), .pullups_off_n(pullups_off_n), .timer_zero(timer_zero));
